// [gauge_ctrl_map.svh]
// Register offsets, field positions and reset values of the gauge control
`ifndef GAUGE_CTRL_MAP_SVH
`define GAUGE_CTRL_MAP_SVH

// Register offsets
`define STAT_ADDR 8'h00
`define CTRL_ADDR 8'h01

// Control field positions
`define CTRL_VBAT_HI 7
`define CTRL_VBAT_LO 6
`define CTRL_PRE_HI 5
`define CTRL_PRE_LO 3
`define CTRL_ROLE_HI 2
`define CTRL_ROLE_LO 1
`define CTRL_SHDN 0

// Status field positions
`define STAT_ID 7
`define STAT_OVF 5
`define STAT_CHI 3
`define STAT_CLO 2
`define STAT_VBAT 1

// Reset values and count limits
`define CTRL_RST 8'h3C
`define CHARGE_RST 16'h7FFF
`define CHARGE_MAX 16'hFFFF
`define CHARGE_MIN 16'h0000

// Pin role codes
`define ROLE_ALERT 2'h2
`define ROLE_CHG_DONE 2'h1
`define ROLE_OFF 2'h0

// Serial bus addresses
`define DEV_BUS_ADDR 7'h64
`define ARA_BUS_ADDR 7'h0C

// Internal quanta per count at prescale one
`define QUANTA_PER_M 11'h008

`endif

// [gauge_ctrl_pkg.sv]
// Types shared by the gauge control logic
package gauge_ctrl_pkg;

   // Kind of request carried from the link to the system domain
   typedef enum logic [1:0] {
      REQ_NONE,
      REQ_CTRL_WR,
      REQ_STAT_CLR,
      REQ_ARA_REL
   } req_kind_t;

   // Pin role field
   typedef logic [1:0] pin_role_t;

endpackage

// [word_crossing.sv]
// Toggle handshake that carries one word between two clock domains
`timescale 1ns/1ps
module word_crossing #(
   parameter int W = 8
) (
   // Source side
   input wire logic src_clk_i,
   input wire logic src_valid_i,
   input wire logic [W-1:0] src_data_i,
   output logic src_busy_o,
   // Destination side
   input wire logic dst_clk_i,
   output logic dst_valid_o,
   output logic [W-1:0] dst_data_o,
   // Common reset
   input wire logic arst_n_i
);

   // Refuse a width the logic cannot carry
   initial begin
      if (W < 1) begin
         $error("word_crossing needs W of at least one");
      end
   end

   logic req_r, req_nxt; // Source request toggle
   logic [W-1:0] hold_r, hold_nxt; // Word held stable while in flight
   logic ack_s1_r, ack_s2_r; // Acknowledge synchroniser
   logic req_s1_r, req_s2_r, req_s3_r; // Request synchroniser and edge
   logic dv_r, dv_nxt; // Destination pulse
   logic [W-1:0] dd_r, dd_nxt; // Destination word

   // Busy until the far side has echoed the toggle
   assign src_busy_o = req_r ^ ack_s2_r;

   // Source next state
   always_comb begin
      req_nxt = req_r;
      hold_nxt = hold_r;
      if (src_valid_i && !src_busy_o) begin
         req_nxt = ~req_r;
         hold_nxt = src_data_i;
      end
   end

   // Source registers
   always_ff @(posedge src_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         req_r <= 1'b0;
         hold_r <= '0;
         ack_s1_r <= 1'b0;
         ack_s2_r <= 1'b0;
      end else begin
         req_r <= req_nxt;
         hold_r <= hold_nxt;
         ack_s1_r <= req_s3_r;
         ack_s2_r <= ack_s1_r;
      end
   end

   // Destination next state, word latched on a toggle edge
   always_comb begin
      dv_nxt = req_s2_r ^ req_s3_r;
      dd_nxt = dd_r;
      if (req_s2_r ^ req_s3_r) begin
         dd_nxt = hold_r;
      end
   end

   // Destination registers
   always_ff @(posedge dst_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         req_s1_r <= 1'b0;
         req_s2_r <= 1'b0;
         req_s3_r <= 1'b0;
         dv_r <= 1'b0;
         dd_r <= '0;
      end else begin
         req_s1_r <= req_r;
         req_s2_r <= req_s1_r;
         req_s3_r <= req_s2_r;
         dv_r <= dv_nxt;
         dd_r <= dd_nxt;
      end
   end

   assign dst_valid_o = dv_r;
   assign dst_data_o = dd_r;

endmodule // word_crossing

// [gauge_ctrl.sv]
// Control register, charge counting and alert pin of the gauge
`timescale 1ns/1ps
`include "gauge_ctrl_map.svh"
module gauge_ctrl #(
   parameter int CHARGE_W = 16,
   parameter logic ID_BIT = 1'b1 // Arbitrary identification value
) (
   // System clock and reset
   input wire logic CLK_SYS_I,
   input wire logic ARST_N_I,
   // Register port from the serial bus engine
   input wire logic LINK_CLK_I,
   input wire logic LINK_WR_I,
   input wire logic LINK_RD_I,
   input wire logic LINK_ARA_I,
   input wire logic [7:0] LINK_ADDR_I,
   input wire logic [7:0] LINK_WDATA_I,
   output logic [7:0] LINK_RDATA_O,
   output logic LINK_ARA_ACK_O,
   output logic LINK_BUSY_O,
   // Analog integrator and battery comparators
   input wire logic RAMP_TOG_I,
   input wire logic RAMP_UP_I,
   input wire logic [2:0] VBAT_BELOW_I,
   output logic ANALOG_SHDN_O,
   // Charge thresholds, same clock
   input wire logic [15:0] THR_HI_I,
   input wire logic [15:0] THR_LO_I,
   // Accumulated charge and status view
   output logic [15:0] CHARGE_COUNT_O,
   output logic [7:0] STATUS_O,
   // Dual-function pin
   input wire logic ALCC_I,
   output logic ALCC_O,
   output logic ALCC_OE_O
);

   // Refuse a count width the saturation logic does not serve
   initial begin
      if (CHARGE_W != 16) begin
         $error("gauge_ctrl supports a 16-bit charge count only");
      end
   end

   localparam int REQ_W = 10; // Request kind plus data byte
   localparam int SNAP_W = 17; // Control, status and alert pending

   // Quantum count at which the prescaler wraps
   function automatic logic [9:0] quantum_limit(input logic [2:0] m);
      logic [10:0] full;
      full = (`QUANTA_PER_M << m) - 11'h001;
      return full[9:0];
   endfunction

   // ------------------------------------------------------------------
   // System domain state
   // ------------------------------------------------------------------
   logic [7:0] ctrl_r, ctrl_nxt; // Control register
   logic [15:0] count_r, count_nxt; // Accumulated charge
   logic [9:0] frac_r, frac_nxt; // Charge below one count
   logic f_ovf_r, f_ovf_nxt; // Overflow/underflow flag
   logic f_chi_r, f_chi_nxt; // Charge high flag
   logic f_clo_r, f_clo_nxt; // Charge low flag
   logic f_vbat_r, f_vbat_nxt; // Battery low flag
   logic pend_r, pend_nxt; // Alert pending on the pin
   logic tog_s1_r, tog_s2_r, tog_s3_r; // Ramp toggle sync and edge
   logic dir_s1_r, dir_s2_r; // Ramp direction sync
   logic [2:0] vb_s1_r, vb_s2_r; // Battery comparator sync
   logic cc_s1_r, cc_s2_r; // Charge done input sync

   // Crossing wires
   logic req_dv; // Request arrived in system domain
   logic [REQ_W-1:0] req_dd; // Request word
   logic snap_dv; // Snapshot arrived in link domain
   logic [SNAP_W-1:0] snap_dd; // Snapshot word
   gauge_ctrl_pkg::req_kind_t req_kind; // Decoded request kind
   logic [7:0] req_data; // Decoded request byte

   // Decoded control fields
   logic [1:0] vbat_sel; // Battery threshold select
   logic [2:0] pre_m; // Prescale exponent
   gauge_ctrl_pkg::pin_role_t role; // Pin role
   logic shdn; // Analog shut down
   logic alert_mode; // Pin acts as alert output
   logic cc_mode; // Pin acts as charge done input
   logic ramp_evt; // One internal quantum seen
   logic sat_evt; // Count tried to pass a limit
   logic vbat_cond; // Battery below selected threshold
   logic chi_cond; // Charge above high threshold
   logic clo_cond; // Charge below low threshold
   logic [7:0] clr_mask; // Status bits cleared by a read
   logic [7:0] status; // Assembled status byte
   logic new_alert; // A flag rose this cycle

   assign req_kind = gauge_ctrl_pkg::req_kind_t'(req_dd[9:8]);
   assign req_data = req_dd[7:0];

   assign vbat_sel = ctrl_r[`CTRL_VBAT_HI:`CTRL_VBAT_LO];
   assign pre_m = ctrl_r[`CTRL_PRE_HI:`CTRL_PRE_LO];
   assign role = ctrl_r[`CTRL_ROLE_HI:`CTRL_ROLE_LO];
   assign shdn = ctrl_r[`CTRL_SHDN];
   // Pin role 11 would act as alert output only; the host keeps out of it
   assign alert_mode = ctrl_r[`CTRL_ROLE_HI];
   assign cc_mode = (role == `ROLE_CHG_DONE);
   assign ramp_evt = tog_s2_r ^ tog_s3_r;

   // Battery comparator picked by the threshold field
   always_comb begin
      unique case (vbat_sel)
         2'h3: vbat_cond = vb_s2_r[2];
         2'h2: vbat_cond = vb_s2_r[1];
         2'h1: vbat_cond = vb_s2_r[0];
         default: vbat_cond = 1'b0; // Alert off
      endcase
   end

   // Threshold comparisons against the live count
   assign chi_cond = (count_r > THR_HI_I);
   assign clo_cond = (count_r < THR_LO_I);

   // Control register and prescaled charge count
   always_comb begin
      ctrl_nxt = ctrl_r;
      count_nxt = count_r;
      frac_nxt = frac_r;
      sat_evt = 1'b0;
      // Host write lands in the control register
      if (req_dv && req_kind == gauge_ctrl_pkg::REQ_CTRL_WR) begin
         ctrl_nxt = req_data;
      end
      if (shdn) begin
         // No charge measured, fraction discarded
         frac_nxt = '0;
      end else if (ramp_evt) begin
         if (dir_s2_r) begin
            // Upward wrap of the prescaler
            if (frac_r >= quantum_limit(pre_m)) begin
               frac_nxt = '0;
               if (count_r == `CHARGE_MAX) begin
                  sat_evt = 1'b1;
               end else begin
                  count_nxt = count_r + 16'h0001;
               end
            end else begin
               frac_nxt = frac_r + 10'h001;
            end
         end else begin
            // Downward wrap of the prescaler
            if (frac_r == 10'h000) begin
               frac_nxt = quantum_limit(pre_m);
               if (count_r == `CHARGE_MIN) begin
                  sat_evt = 1'b1;
               end else begin
                  count_nxt = count_r - 16'h0001;
               end
            end else begin
               frac_nxt = frac_r - 10'h001;
            end
         end
      end
      // Charge done input forces a full count
      if (cc_mode && cc_s2_r) begin
         count_nxt = `CHARGE_MAX;
      end
   end

   // Status flags: the setting condition always wins over a read clear
   always_comb begin
      clr_mask = '0;
      if (req_dv && req_kind == gauge_ctrl_pkg::REQ_STAT_CLR) begin
         clr_mask = req_data;
      end
      f_ovf_nxt = sat_evt | (f_ovf_r & ~clr_mask[`STAT_OVF]);
      f_chi_nxt = chi_cond | (f_chi_r & ~clr_mask[`STAT_CHI]);
      f_clo_nxt = clo_cond | (f_clo_r & ~clr_mask[`STAT_CLO]);
      f_vbat_nxt = vbat_cond | (f_vbat_r & ~clr_mask[`STAT_VBAT]);
   end

   // Status byte as the host sees it
   always_comb begin
      status = 8'h00;
      status[`STAT_ID] = ID_BIT;
      status[`STAT_OVF] = f_ovf_r;
      status[`STAT_CHI] = f_chi_r;
      status[`STAT_CLO] = f_clo_r;
      status[`STAT_VBAT] = f_vbat_r;
   end

   // Alert pending: raised by a rising flag, dropped by alert response
   always_comb begin
      new_alert = (f_ovf_nxt & ~f_ovf_r) | (f_chi_nxt & ~f_chi_r) |
         (f_clo_nxt & ~f_clo_r) | (f_vbat_nxt & ~f_vbat_r);
      pend_nxt = pend_r;
      if (req_dv && req_kind == gauge_ctrl_pkg::REQ_ARA_REL) begin
         pend_nxt = 1'b0;
      end
      if (new_alert) begin
         pend_nxt = 1'b1;
      end
      if (!alert_mode) begin
         pend_nxt = 1'b0;
      end
   end

   // System domain registers
   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         ctrl_r <= `CTRL_RST;
         count_r <= `CHARGE_RST;
         frac_r <= '0;
         f_ovf_r <= 1'b0;
         f_chi_r <= 1'b0;
         f_clo_r <= 1'b0;
         f_vbat_r <= 1'b0;
         pend_r <= 1'b0;
         tog_s1_r <= 1'b0;
         tog_s2_r <= 1'b0;
         tog_s3_r <= 1'b0;
         dir_s1_r <= 1'b0;
         dir_s2_r <= 1'b0;
         vb_s1_r <= '0;
         vb_s2_r <= '0;
         cc_s1_r <= 1'b0;
         cc_s2_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         count_r <= count_nxt;
         frac_r <= frac_nxt;
         f_ovf_r <= f_ovf_nxt;
         f_chi_r <= f_chi_nxt;
         f_clo_r <= f_clo_nxt;
         f_vbat_r <= f_vbat_nxt;
         pend_r <= pend_nxt;
         tog_s1_r <= RAMP_TOG_I;
         tog_s2_r <= tog_s1_r;
         tog_s3_r <= tog_s2_r;
         dir_s1_r <= RAMP_UP_I;
         dir_s2_r <= dir_s1_r;
         vb_s1_r <= VBAT_BELOW_I;
         vb_s2_r <= vb_s1_r;
         cc_s1_r <= ALCC_I;
         cc_s2_r <= cc_s1_r;
      end
   end

   // Open-drain pin: pulls low only while an alert is pending
   assign ALCC_O = 1'b0;
   assign ALCC_OE_O = pend_r;
   assign ANALOG_SHDN_O = shdn;
   assign CHARGE_COUNT_O = count_r;
   assign STATUS_O = status;

   // ------------------------------------------------------------------
   // Link domain
   // ------------------------------------------------------------------
   logic [7:0] snap_ctrl_r, snap_ctrl_nxt; // Control copy for reads
   logic [7:0] snap_stat_r, snap_stat_nxt; // Status copy for reads
   logic snap_pend_r, snap_pend_nxt; // Alert pending copy
   logic [7:0] rdata_r, rdata_nxt; // Read data to the engine
   logic ara_ack_r, ara_ack_nxt; // Alert response acknowledge
   logic req_v; // Request offered to the crossing
   logic [REQ_W-1:0] req_w; // Request word offered

   // Reads, writes and alert response from the serial engine
   always_comb begin
      snap_ctrl_nxt = snap_ctrl_r;
      snap_stat_nxt = snap_stat_r;
      snap_pend_nxt = snap_pend_r;
      rdata_nxt = rdata_r;
      ara_ack_nxt = 1'b0;
      req_v = 1'b0;
      req_w = {gauge_ctrl_pkg::REQ_NONE, 8'h00};
      if (snap_dv) begin
         snap_ctrl_nxt = snap_dd[16:9];
         snap_stat_nxt = snap_dd[8:1];
         snap_pend_nxt = snap_dd[0];
      end
      if (LINK_WR_I) begin
         if (LINK_ADDR_I == `CTRL_ADDR) begin
            req_v = 1'b1;
            req_w = {gauge_ctrl_pkg::REQ_CTRL_WR, LINK_WDATA_I};
         end
      end else if (LINK_ARA_I) begin
         // Acknowledge only while alerting; own address given on every alert response
         ara_ack_nxt = snap_pend_r;
         rdata_nxt = {`DEV_BUS_ADDR, 1'b1};
         if (snap_pend_r) begin
            req_v = 1'b1;
            req_w = {gauge_ctrl_pkg::REQ_ARA_REL, 8'h00};
         end
      end else if (LINK_RD_I) begin
         unique case (LINK_ADDR_I)
            `CTRL_ADDR: begin
               rdata_nxt = snap_ctrl_r;
            end
            `STAT_ADDR: begin
               // Clear only what was actually shown to the host
               rdata_nxt = snap_stat_r;
               req_v = 1'b1;
               req_w = {gauge_ctrl_pkg::REQ_STAT_CLR, snap_stat_r};
            end
            default: begin
               rdata_nxt = 8'h00;
            end
         endcase
      end
   end

   // Link domain registers
   always_ff @(posedge LINK_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         snap_ctrl_r <= `CTRL_RST;
         snap_stat_r <= 8'h00;
         snap_pend_r <= 1'b0;
         rdata_r <= 8'h00;
         ara_ack_r <= 1'b0;
      end else begin
         snap_ctrl_r <= snap_ctrl_nxt;
         snap_stat_r <= snap_stat_nxt;
         snap_pend_r <= snap_pend_nxt;
         rdata_r <= rdata_nxt;
         ara_ack_r <= ara_ack_nxt;
      end
   end

   assign LINK_RDATA_O = rdata_r;
   assign LINK_ARA_ACK_O = ara_ack_r;

   // Link requests into the system domain
   word_crossing #(
      .W(REQ_W)
   ) u_req_cross (
      .src_clk_i(LINK_CLK_I),
      .src_valid_i(req_v),
      .src_data_i(req_w),
      .src_busy_o(LINK_BUSY_O),
      .dst_clk_i(CLK_SYS_I),
      .dst_valid_o(req_dv),
      .dst_data_o(req_dd),
      .arst_n_i(ARST_N_I)
   );

   // Free-running snapshot of readable state into the link domain
   word_crossing #(
      .W(SNAP_W)
   ) u_snap_cross (
      .src_clk_i(CLK_SYS_I),
      .src_valid_i(1'b1),
      .src_data_i({ctrl_r, status, pend_r}),
      .src_busy_o(),
      .dst_clk_i(LINK_CLK_I),
      .dst_valid_o(snap_dv),
      .dst_data_o(snap_dd),
      .arst_n_i(ARST_N_I)
   );

endmodule // gauge_ctrl

// [gauge_ctrl_checker.sv]
// Port checker of the gauge control block
`timescale 1ns/1ps
module gauge_ctrl_checker #(
   parameter logic ID_BIT = 1'b1
) (
   // Clocks and reset
   input wire logic CLK_SYS_I,
   input wire logic ARST_N_I,
   input wire logic LINK_CLK_I,
   // Register link
   input wire logic LINK_WR_I,
   input wire logic LINK_ARA_I,
   input wire logic [7:0] LINK_ADDR_I,
   input wire logic [7:0] LINK_RDATA_O,
   input wire logic LINK_ARA_ACK_O,
   input wire logic LINK_BUSY_O,
   // Counting and pin
   input wire logic ANALOG_SHDN_O,
   input wire logic [15:0] CHARGE_COUNT_O,
   input wire logic [7:0] STATUS_O,
   input wire logic ALCC_I,
   input wire logic ALCC_O,
   input wire logic ALCC_OE_O
);
   // Control write starts the crossing next cycle
   wr_busy_a: assert property (@(posedge LINK_CLK_I)
      disable iff (!ARST_N_I) LINK_WR_I && LINK_ADDR_I == 8'h01 &&
      !LINK_BUSY_O |=> LINK_BUSY_O) else $error("write not taken");
   // Alert response carries own address and read bit
   ara_byte_a: assert property (@(posedge LINK_CLK_I)
      disable iff (!ARST_N_I) LINK_ARA_ACK_O |-> LINK_RDATA_O == 8'hC9)
      else $error("alert response byte wrong");
   // Acknowledge is a one-cycle answer to a request
   ara_pulse_a: assert property (@(posedge LINK_CLK_I)
      disable iff (!ARST_N_I) $rose(LINK_ARA_ACK_O) |->
      $past(LINK_ARA_I) ##1 !LINK_ARA_ACK_O) else $error("ack shape wrong");
   // Pin released soon after the alert response
   alert_release_a: assert property (@(posedge LINK_CLK_I)
      disable iff (!ARST_N_I) $rose(LINK_ARA_ACK_O) |-> ##[1:16] !ALCC_OE_O)
      else $error("alert not released");
   // Identification bit kept, reserved bits 6 and 4 zero
   status_id_a: assert property (@(posedge CLK_SYS_I)
      disable iff (!ARST_N_I) STATUS_O[7] == ID_BIT && STATUS_O[6] == 1'b0
      && STATUS_O[4] == 1'b0) else $error("status fixed bits wrong");
   // Count moves one step or is forced full
   count_step_a: assert property (@(posedge CLK_SYS_I)
      disable iff (!ARST_N_I) CHARGE_COUNT_O != $past(CHARGE_COUNT_O) |->
      CHARGE_COUNT_O == $past(CHARGE_COUNT_O) + 16'h0001 ||
      CHARGE_COUNT_O == $past(CHARGE_COUNT_O) - 16'h0001 ||
      CHARGE_COUNT_O == 16'hFFFF) else $error("count jumped");
   // Full count never wraps to empty
   no_wrap_a: assert property (@(posedge CLK_SYS_I)
      disable iff (!ARST_N_I) $past(CHARGE_COUNT_O) == 16'hFFFF |->
      CHARGE_COUNT_O != 16'h0000) else $error("count wrapped");
   // No counting while the analog part is down
   shdn_freeze_a: assert property (@(posedge CLK_SYS_I)
      disable iff (!ARST_N_I) (ANALOG_SHDN_O && !ALCC_I)[*4] |=>
      $stable(CHARGE_COUNT_O)) else $error("counted in shutdown");
   // Open-drain output only ever pulls low
   pin_low_a: assert property (@(posedge CLK_SYS_I)
      disable iff (!ARST_N_I) ALCC_O == 1'b0) else $error("pin driven high");
endmodule // gauge_ctrl_checker

bind gauge_ctrl gauge_ctrl_checker #(.ID_BIT(ID_BIT)) checker_i (
   .CLK_SYS_I, .ARST_N_I, .LINK_CLK_I, .LINK_WR_I, .LINK_ARA_I,
   .LINK_ADDR_I, .LINK_RDATA_O, .LINK_ARA_ACK_O, .LINK_BUSY_O,
   .ANALOG_SHDN_O, .CHARGE_COUNT_O, .STATUS_O, .ALCC_I, .ALCC_O,
   .ALCC_OE_O);

// [link_host.sv]
// Host model of the register link, one request at a time
`timescale 1ns/1ps
module link_host (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Requests
   output logic wr_o,
   output logic rd_o,
   output logic ara_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o,
   // Answers
   input wire logic [7:0] rdata_i,
   input wire logic ack_i,
   input wire logic busy_i
);
   // Idle lines at time zero
   initial begin
      {wr_o, rd_o, ara_o} = 3'h0;
      {addr_o, wdata_o} = 16'h0000;
   end
   // Bounded wait for the crossing to go idle
   task automatic idle();
      int n;
      n = 0;
      while ((busy_i !== 1'b0 || !arst_n_i) && n < 200) begin
         @(posedge clk_i);
         n++;
      end
   endtask
   // Kind 0 write, 1 read, 2 alert response; answer one cycle on
   task automatic req(input int k, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] q, output logic ack);
      if (k == 0 && a == 8'h01 && d[2:1] == 2'h3) d[2] = 1'b0;
      idle();
      @(posedge clk_i);
      wr_o <= (k == 0);
      rd_o <= (k == 1);
      ara_o <= (k == 2);
      addr_o <= a;
      wdata_o <= d;
      @(posedge clk_i);
      {wr_o, rd_o, ara_o} <= 3'h0;
      addr_o <= ~a;
      wdata_o <= ~d;
      #1;
      q = rdata_i;
      ack = ack_i;
   endtask
endmodule // link_host

// [tb.sv]
// Self-checking bench of the gauge control block
`timescale 1ns/1ps
module tb;
   // Bench signals
   logic clk_sys, lclk, arst_n, wr, rd, ara, ack, busy, shdn, tog, up;
   logic alcc_o, alcc_oe, cc_drv, ak;
   logic [7:0] addr, wdata, rdata, status, q, v;
   logic [2:0] vbelow;
   logic [15:0] thr_hi, thr_lo, count, c0;
   int n_mismatch, tests_run;
   wire logic pin_w;
   // Pin level: device pulls low, else charger drives
   assign pin_w = alcc_oe ? alcc_o : cc_drv;

   gauge_ctrl uut (.CLK_SYS_I(clk_sys), .ARST_N_I(arst_n),
      .LINK_CLK_I(lclk), .LINK_WR_I(wr), .LINK_RD_I(rd), .LINK_ARA_I(ara),
      .LINK_ADDR_I(addr), .LINK_WDATA_I(wdata), .LINK_RDATA_O(rdata),
      .LINK_ARA_ACK_O(ack), .LINK_BUSY_O(busy), .RAMP_TOG_I(tog),
      .RAMP_UP_I(up), .VBAT_BELOW_I(vbelow), .ANALOG_SHDN_O(shdn),
      .THR_HI_I(thr_hi), .THR_LO_I(thr_lo), .CHARGE_COUNT_O(count),
      .STATUS_O(status), .ALCC_I(pin_w), .ALCC_O(alcc_o),
      .ALCC_OE_O(alcc_oe));
   link_host host (.clk_i(lclk), .arst_n_i(arst_n), .wr_o(wr), .rd_o(rd),
      .ara_o(ara), .addr_o(addr), .wdata_o(wdata), .rdata_i(rdata),
      .ack_i(ack), .busy_i(busy));

   // Clocks, link one unrelated in phase
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   initial begin
      lclk = 1'b0;
      #3;
      forever #6 lclk = ~lclk;
   end
   // Expected control byte from its fields
   function automatic logic [7:0] ctl(input logic [1:0] vb,
      input logic [2:0] m, input logic [1:0] role, input logic sd);
      return {vb, m, role, sd};
   endfunction
   // Quanta per count for prescale code k
   function automatic int quanta(input int k);
      return 8 << k;
   endfunction
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Integrator ramp toggles, then settle
   task automatic ramp(input int n);
      repeat (n) begin
         repeat (3) @(posedge clk_sys);
         tog <= ~tog;
      end
      repeat (8) @(posedge clk_sys);
   endtask
   // Control write, wait until applied
   task automatic wctl(input logic [7:0] d);
      host.req(0, 8'h01, d, q, ak);
      host.idle();
      repeat (4) @(posedge clk_sys);
   endtask
   // Register read after the snapshot lag
   task automatic rreg(input logic [7:0] a);
      repeat (20) @(posedge lclk);
      host.req(1, a, 8'h00, q, ak);
      @(posedge clk_sys);
   endtask
   // Alert response after the snapshot lag, then settle
   task automatic aresp();
      repeat (20) @(posedge lclk);
      host.req(2, 8'h00, 8'h00, q, ak);
      repeat (8) @(posedge clk_sys);
   endtask
   // Counts and verdict
   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Watchdog against hangs
   initial begin
      #1_000_000;
      n_mismatch++;
      results();
   end

   // Main sequence
   initial begin
      {arst_n, tog, cc_drv, up} = 4'h1;
      vbelow = 3'h0;
      thr_hi = 16'hFFFF;
      thr_lo = 16'h0000;
      void'($urandom(32'h45DC));
      repeat (6) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (6) @(posedge lclk);
      @(posedge clk_sys);
      chk(count, 16'h7FFF);
      chk(shdn, 1'b0);
      chk(alcc_oe, 1'b0);
      rreg(8'h01);
      chk(q, ctl(2'h0, 3'h7, 2'h2, 1'b0));
      $display("test reset done");
      repeat (6) begin
         v = 8'($urandom());
         if (v[2:1] == 2'h3) v[2] = 1'b0;
         wctl(v);
         chk(shdn, v[0]);
         host.req(0, 8'($urandom_range(255, 2)), ~v, q, ak);
         rreg(8'h01);
         chk(q, v);
      end
      rreg(8'h09);
      chk(q, 8'h00);
      $display("test control done");
      for (int k = 0; k < 8; k++) begin
         wctl(ctl(2'h0, k[2:0], 2'h0, 1'b1));
         wctl(ctl(2'h0, k[2:0], 2'h0, 1'b0));
         c0 = count;
         ramp(quanta(k) - 1);
         chk(count, c0);
         ramp(1);
         chk(count, c0 + 16'h0001);
      end
      $display("test prescale done");
      ramp(5);
      wctl(ctl(2'h0, 3'h0, 2'h0, 1'b1));
      c0 = count;
      ramp(8);
      chk(count, c0);
      wctl(ctl(2'h0, 3'h0, 2'h0, 1'b0));
      ramp(7);
      chk(count, c0);
      ramp(1);
      chk(count, c0 + 16'h0001);
      $display("test shutdown done");
      wctl(ctl(2'h0, 3'h0, 2'h1, 1'b0));
      cc_drv <= 1'b1;
      repeat (8) @(posedge clk_sys);
      chk(count, 16'hFFFF);
      cc_drv <= 1'b0;
      wctl(ctl(2'h0, 3'h0, 2'h0, 1'b0));
      up <= 1'b0;
      ramp(8);
      cc_drv <= 1'b1;
      repeat (8) @(posedge clk_sys);
      chk(count, 16'hFFFE);
      cc_drv <= 1'b0;
      up <= 1'b1;
      ramp(8);
      wctl(ctl(2'h0, 3'h0, 2'h2, 1'b0));
      chk(alcc_oe, 1'b0);
      ramp(8);
      chk(count, 16'hFFFF);
      chk(status[5], 1'b1);
      chk(alcc_oe, 1'b1);
      aresp();
      chk(ak, 1'b1);
      chk(alcc_oe, 1'b0);
      up <= 1'b0;
      ramp(8);
      chk(count, 16'hFFFE);
      rreg(8'h00);
      chk(q[5], 1'b1);
      repeat (20) @(posedge clk_sys);
      chk(status, 8'h80);
      {thr_hi, thr_lo} <= {16'hFFFD, 16'hFFFF};
      repeat (8) @(posedge clk_sys);
      chk(status, 8'h8C);
      chk(alcc_oe, 1'b1);
      {thr_hi, thr_lo} <= {16'hFFFF, 16'h0000};
      aresp();
      chk(ak, 1'b1);
      chk(alcc_oe, 1'b0);
      rreg(8'h00);
      repeat (20) @(posedge clk_sys);
      chk(status, 8'h80);
      $display("test pin done");
      for (int t = 1; t < 4; t++) begin
         wctl(ctl(t[1:0], 3'h0, 2'h2, 1'b0));
         vbelow <= 3'(3'h1 << (t - 1));
         repeat (8) @(posedge clk_sys);
         chk(status[1], 1'b1);
         chk(alcc_oe, 1'b1);
         aresp();
         chk(ak, 1'b1);
         vbelow <= 3'h0;
         rreg(8'h00);
         repeat (20) @(posedge clk_sys);
         chk(status[1], 1'b0);
      end
      wctl(ctl(2'h3, 3'h0, 2'h0, 1'b0));
      vbelow <= 3'h4;
      repeat (8) @(posedge clk_sys);
      chk(alcc_oe, 1'b0);
      aresp();
      chk(ak, 1'b0);
      wctl(ctl(2'h0, 3'h0, 2'h2, 1'b0));
      rreg(8'h00);
      repeat (20) @(posedge clk_sys);
      chk(status[1], 1'b0);
      $display("test battery done");
      results();
   end
endmodule // tb
